// >>> pkg/bcc_pkg.sv
// Package for the bridge chip control register block: offsets, field layout,
// reset values, power-state codes and timing constants.
// Assumes a 125 MHz core clock and an APB register bus with 32-bit data.
package bcc_pkg;

   // Register byte offsets.
   localparam logic [7:0] OFS_CTRL = 8'h40;
   localparam logic [7:0] OFS_RSVD = 8'h44;
   localparam logic [7:0] OFS_ARB = 8'h48;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h80;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h84;
   localparam logic [7:0] OFS_IRQ_EN = 8'h88;

   // The control word implements bits 31:15; bits 14:0 read as zero here.
   localparam int CTRL_LSB = 15;
   localparam logic [31:0] CTRL_RST = 32'hc920_0000;
   localparam logic [4:0] ARB_RST = 5'h1f;
   localparam logic [31:0] RSVD_VALUE = 32'h0000_0000;
   localparam int RETRY_ST_BIT = 16;

   // Interrupt status bit positions.
   localparam int IRQ_RETRY = 0;
   localparam int IRQ_DISCARD = 1;
   localparam int IRQ_CFG = 2;
   localparam int IRQ_CPL = 3;
   localparam int IRQ_N = 4;

   // Retry limits; zero means no limit.
   localparam logic [31:0] RETRY_LIM1 = 32'h0000_0100;
   localparam logic [31:0] RETRY_LIM2 = 32'h0001_0000;
   localparam logic [31:0] RETRY_LIM3 = 32'h8000_0000;

   // Discard timer lengths in PCI clocks.
   localparam logic [15:0] DT_SHORT_CLKS = 16'h0040;
   localparam int DT_LONG_CLKS = 32768;
   localparam int DT_MID_CLKS = 1024;

   // Timer expiry times in microseconds and the clock rate in MHz.
   localparam int CLK_MHZ = 125;
   localparam int CFG_T0_US = 25;
   localparam int CFG_T1_US = 500;
   localparam int CFG_T2_US = 5000;
   localparam int CFG_T3_US = 25000;
   localparam int CPL_T0_US = 50;
   localparam int CPL_T1_US = 10000;
   localparam int CPL_T2_US = 50000;
   localparam int CFG_CYC0 = CFG_T0_US * CLK_MHZ;
   localparam int CFG_CYC1 = CFG_T1_US * CLK_MHZ;
   localparam int CFG_CYC2 = CFG_T2_US * CLK_MHZ;
   localparam int CFG_CYC3 = CFG_T3_US * CLK_MHZ;
   localparam int CPL_CYC0 = CPL_T0_US * CLK_MHZ;
   localparam int CPL_CYC1 = CPL_T1_US * CLK_MHZ;
   localparam int CPL_CYC2 = CPL_T2_US * CLK_MHZ;
   localparam logic [1:0] CPL_OFF = 2'b11;

   typedef enum logic [1:0] {
      PM_L0 = 2'b00,
      PM_L0S = 2'b01,
      PM_L1S = 2'b10,
      PM_L1 = 2'b11
   } bcc_pm_t;

   // Control word fields, laid out as bits 31 down to 15.
   typedef struct packed {
      logic psave_l0s;
      logic psave;
      logic [2:0] iso_tc;
      logic iso_en;
      logic [1:0] cpl_sel;
      logic in_order;
      logic [1:0] cfg_sel;
      logic dt_short;
      logic dt_dis;
      logic [1:0] retry_lim;
      logic retry_st;
      logic fc_every_one;
   } bcc_ctrl_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [3:0] pstrb;
      logic [31:0] pwdata;
   } bcc_apb_req_t;

   typedef struct packed {
      logic run;
      logic [23:0] cnt;
      logic exp;
   } bcc_timer_t;

   typedef struct packed {
      bcc_ctrl_t ctrl;
      logic [4:0] arb_en;
      logic [IRQ_N-1:0] irq_st;
      logic [IRQ_N-1:0] irq_en;
      logic [31:0] prdata;
      logic fc_half;
      logic fc_update;
      logic [31:0] retry_cnt;
      logic retry_exp;
      logic dt_run;
      logic [15:0] dt_cnt;
      logic dt_exp;
      bcc_timer_t cfg;
      bcc_timer_t cpl;
      logic [2:0] mem_tc;
      logic clk_gate;
      logic [4:0] req_masked;
   } bcc_state_t;

endpackage

// >>> verilog/bcc_regs.sv
// Chip control and arbiter-enable registers of the bridge, with the small
// engines they steer: credit-update pacing, retry limit, discard timer,
// configuration retry and completion timers, traffic class and clock gating.
// Assumes an APB master on the register side and core event pulses that are
// synchronous to clk_sys.
`timescale 1ns/1ps

module bcc_regs #(
   parameter logic [23:0] CFG_CYC0 = 24'(bcc_pkg::CFG_CYC0),
   parameter logic [23:0] CFG_CYC1 = 24'(bcc_pkg::CFG_CYC1),
   parameter logic [23:0] CFG_CYC2 = 24'(bcc_pkg::CFG_CYC2),
   parameter logic [23:0] CFG_CYC3 = 24'(bcc_pkg::CFG_CYC3),
   parameter logic [23:0] CPL_CYC0 = 24'(bcc_pkg::CPL_CYC0),
   parameter logic [23:0] CPL_CYC1 = 24'(bcc_pkg::CPL_CYC1),
   parameter logic [23:0] CPL_CYC2 = 24'(bcc_pkg::CPL_CYC2),
   parameter logic [15:0] DT_LONG_CLKS = 16'(bcc_pkg::DT_LONG_CLKS),
   parameter logic [15:0] DT_MID_CLKS = 16'(bcc_pkg::DT_MID_CLKS)
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire bcc_pkg::bcc_apb_req_t apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic credit_freed,
   output logic fc_update,
   input wire logic pci_retry,
   input wire logic pci_retry_done,
   output logic retry_expired,
   input wire logic pci_clk_tick,
   input wire logic brctl_discard_sel,
   input wire logic dt_start,
   input wire logic dt_stop,
   output logic dt_expired,
   input wire logic cfg_start,
   input wire logic cfg_stop,
   output logic cfg_expired,
   input wire logic cpl_start,
   input wire logic cpl_done,
   output logic cpl_expired,
   output logic dt_in_order,
   output logic [2:0] mem_tc,
   input wire bcc_pkg::bcc_pm_t pm_state,
   output logic clk_gate,
   input wire logic [4:0] arb_req,
   output logic [4:0] arb_req_masked
);

   bcc_pkg::bcc_state_t s_q;
   bcc_pkg::bcc_state_t s_d;
   logic [31:0] wmask;
   logic [31:0] wval;
   logic [31:0] ctrl_mrg;
   logic [31:0] ctrl_word;
   logic [31:0] rd_val;
   logic rd_hit;
   logic setup;
   logic wr_acc;
   logic [31:0] retry_lim;
   logic [15:0] dt_lim;
   logic [23:0] cfg_lim;
   logic [23:0] cpl_lim;
   logic [bcc_pkg::IRQ_N-1:0] ev;
   logic [bcc_pkg::IRQ_N-1:0] clr;

   // Byte enables turn into a bit mask, one byte lane per generate pass.
   for (genvar g = 0; g < 4; g++) begin : g_lane
      assign wmask[8*g +: 8] = {8{apb_req.pstrb[g]}};
   end

   assign setup = apb_req.psel && !apb_req.penable;
   assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign ctrl_word = {s_q.ctrl, 15'h0000};

   // Read decode; the result is captured in the setup phase so that prdata
   // comes from a flop and the access phase needs no wait state.
   always_comb begin
      rd_hit = 1'b1;
      rd_val = 32'h0000_0000;
      if (apb_req.paddr == bcc_pkg::OFS_CTRL) begin
         rd_val = ctrl_word;
      end else if (apb_req.paddr == bcc_pkg::OFS_RSVD) begin
         rd_val = bcc_pkg::RSVD_VALUE;
      end else if (apb_req.paddr == bcc_pkg::OFS_ARB) begin
         rd_val = {27'h0000000, s_q.arb_en};
      end else if (apb_req.paddr == bcc_pkg::OFS_IRQ_STAT) begin
         rd_val = {28'h0000000, s_q.irq_st};
      end else if (apb_req.paddr == bcc_pkg::OFS_IRQ_CLR) begin
         rd_val = 32'h0000_0000;
      end else if (apb_req.paddr == bcc_pkg::OFS_IRQ_EN) begin
         rd_val = {28'h0000000, s_q.irq_en};
      end else begin
         rd_hit = 1'b0;
      end
   end

   // Limit selection for the engines.
   always_comb begin
      case (s_q.ctrl.retry_lim)
         2'b01: retry_lim = bcc_pkg::RETRY_LIM1;
         2'b10: retry_lim = bcc_pkg::RETRY_LIM2;
         2'b11: retry_lim = bcc_pkg::RETRY_LIM3;
         default: retry_lim = 32'h0000_0000;
      endcase
      if (s_q.ctrl.dt_short) begin
         dt_lim = bcc_pkg::DT_SHORT_CLKS;
      end else if (brctl_discard_sel) begin
         dt_lim = DT_MID_CLKS;
      end else begin
         dt_lim = DT_LONG_CLKS;
      end
      case (s_q.ctrl.cfg_sel)
         2'b00: cfg_lim = CFG_CYC0;
         2'b01: cfg_lim = CFG_CYC1;
         2'b10: cfg_lim = CFG_CYC2;
         default: cfg_lim = CFG_CYC3;
      endcase
      case (s_q.ctrl.cpl_sel)
         2'b00: cpl_lim = CPL_CYC0;
         2'b01: cpl_lim = CPL_CYC1;
         default: cpl_lim = CPL_CYC2;
      endcase
   end

   always_comb begin
      s_d = s_q;
      wval = apb_req.pwdata;
      s_d.fc_update = 1'b0;
      s_d.retry_exp = 1'b0;
      s_d.dt_exp = 1'b0;
      s_d.cfg.exp = 1'b0;
      s_d.cpl.exp = 1'b0;
      clr = '0;
      ctrl_mrg = (ctrl_word & ~wmask) | (wval & wmask);
      if (setup) begin
         s_d.prdata = rd_val;
      end

      // Register writes take effect at the access-phase edge.
      if (wr_acc) begin
         if (apb_req.paddr == bcc_pkg::OFS_CTRL) begin
            s_d.ctrl = ctrl_mrg[31:bcc_pkg::CTRL_LSB];
            // The status bit is write-one-to-clear, not a plain field.
            s_d.ctrl.retry_st = s_q.ctrl.retry_st
               & ~(wval[bcc_pkg::RETRY_ST_BIT] & wmask[bcc_pkg::RETRY_ST_BIT]);
         end else if (apb_req.paddr == bcc_pkg::OFS_ARB) begin
            if (apb_req.pstrb[0]) begin
               s_d.arb_en = wval[4:0];
            end
         end else if (apb_req.paddr == bcc_pkg::OFS_IRQ_CLR) begin
            if (apb_req.pstrb[0]) begin
               clr = wval[bcc_pkg::IRQ_N-1:0];
            end
         end else if (apb_req.paddr == bcc_pkg::OFS_IRQ_EN) begin
            if (apb_req.pstrb[0]) begin
               s_d.irq_en = wval[bcc_pkg::IRQ_N-1:0];
            end
         end
      end

      // Credit pacing: with pacing bit 0 every second freed credit sends one.
      if (credit_freed) begin
         if (s_q.ctrl.fc_every_one) begin
            s_d.fc_update = 1'b1;
            s_d.fc_half = 1'b0;
         end else begin
            s_d.fc_update = s_q.fc_half;
            s_d.fc_half = !s_q.fc_half;
         end
      end

      // Retry counter; a limit of zero never expires.
      if (pci_retry_done) begin
         s_d.retry_cnt = 32'h0000_0000;
      end else if (pci_retry && retry_lim != 32'h0000_0000) begin
         if (s_q.retry_cnt + 32'h0000_0001 >= retry_lim) begin
            s_d.retry_exp = 1'b1;
            s_d.retry_cnt = 32'h0000_0000;
         end else begin
            s_d.retry_cnt = s_q.retry_cnt + 32'h0000_0001;
         end
      end
      if (s_d.retry_exp) begin
         s_d.ctrl.retry_st = 1'b1;
      end

      // Discard timer, counted in PCI clock ticks.
      if (dt_stop || s_q.ctrl.dt_dis) begin
         s_d.dt_run = 1'b0;
         s_d.dt_cnt = 16'h0000;
      end else if (dt_start) begin
         s_d.dt_run = 1'b1;
         s_d.dt_cnt = 16'h0000;
      end else if (s_q.dt_run && pci_clk_tick) begin
         if (s_q.dt_cnt >= dt_lim - 16'h0001) begin
            s_d.dt_exp = 1'b1;
            s_d.dt_run = 1'b0;
         end else begin
            s_d.dt_cnt = s_q.dt_cnt + 16'h0001;
         end
      end

      // Configuration request retry timer.
      if (cfg_stop) begin
         s_d.cfg.run = 1'b0;
      end else if (cfg_start) begin
         s_d.cfg.run = 1'b1;
         s_d.cfg.cnt = 24'h000000;
      end else if (s_q.cfg.run) begin
         if (s_q.cfg.cnt >= cfg_lim - 24'h000001) begin
            s_d.cfg.exp = 1'b1;
            s_d.cfg.run = 1'b0;
         end else begin
            s_d.cfg.cnt = s_q.cfg.cnt + 24'h000001;
         end
      end

      // Completion timer; the disabled setting drops a running timer.
      if (cpl_done || s_q.ctrl.cpl_sel == bcc_pkg::CPL_OFF) begin
         s_d.cpl.run = 1'b0;
      end else if (cpl_start) begin
         s_d.cpl.run = 1'b1;
         s_d.cpl.cnt = 24'h000000;
      end else if (s_q.cpl.run) begin
         if (s_q.cpl.cnt >= cpl_lim - 24'h000001) begin
            s_d.cpl.exp = 1'b1;
            s_d.cpl.run = 1'b0;
         end else begin
            s_d.cpl.cnt = s_q.cpl.cnt + 24'h000001;
         end
      end
      // Sticky interrupt status; a new event wins over a clear.
      ev = {s_d.cpl.exp, s_d.cfg.exp, s_d.dt_exp, s_d.retry_exp};
      s_d.irq_st = (s_q.irq_st & ~clr) | ev;

      s_d.mem_tc = s_q.ctrl.iso_en ? s_q.ctrl.iso_tc : 3'b000;
      s_d.clk_gate = (s_q.ctrl.psave && (pm_state == bcc_pkg::PM_L1S
         || pm_state == bcc_pkg::PM_L1))
         || (s_q.ctrl.psave_l0s && pm_state == bcc_pkg::PM_L0S);
      s_d.req_masked = arb_req & s_q.arb_en;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_q <= '0;
         s_q.ctrl <= bcc_pkg::CTRL_RST[31:bcc_pkg::CTRL_LSB];
         s_q.arb_en <= bcc_pkg::ARB_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.prdata;
   assign pready = 1'b1;
   assign pslverr = apb_req.psel && apb_req.penable && !rd_hit;
   assign irq = |(s_q.irq_st & s_q.irq_en);
   assign fc_update = s_q.fc_update;
   assign retry_expired = s_q.retry_exp;
   assign dt_expired = s_q.dt_exp;
   assign cfg_expired = s_q.cfg.exp;
   assign cpl_expired = s_q.cpl.exp;
   assign dt_in_order = s_q.ctrl.in_order;
   assign mem_tc = s_q.mem_tc;
   assign clk_gate = s_q.clk_gate;
   assign arb_req_masked = s_q.req_masked;

endmodule

// >>> verification/bcc_regs_props.sv
// Concurrent checks on the ports of the chip control register block.
// Assumes one clock domain with an asynchronous active-high reset.
`timescale 1ns/1ps
module bcc_regs_chk (
   input wire logic clk_sys,
   input wire logic rst,
   input wire bcc_pkg::bcc_apb_req_t apb_req,
   input wire logic [31:0] prdata,
   input wire logic credit_freed,
   input wire logic fc_update,
   input wire logic pci_retry,
   input wire logic retry_expired,
   input wire logic cfg_stop,
   input wire logic cfg_expired,
   input wire logic cpl_done,
   input wire logic cpl_expired,
   input wire bcc_pkg::bcc_pm_t pm_state,
   input wire logic clk_gate,
   input wire logic [4:0] arb_req,
   input wire logic [4:0] arb_req_masked
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic rd;
   assign rd = apb_req.psel && apb_req.penable && !apb_req.pwrite;
   property p_rsvd;
      rd && apb_req.paddr == bcc_pkg::OFS_RSVD |-> prdata == 32'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved word read nonzero");
   property p_arb_hi;
      rd && apb_req.paddr == bcc_pkg::OFS_ARB |-> prdata[31:5] == 27'h0;
   endproperty
   a_arb_hi: assert property (p_arb_hi) else $error("arbiter word upper bits set");
   property p_fc;
      fc_update |-> $past(credit_freed);
   endproperty
   a_fc: assert property (p_fc) else $error("credit update without freed credit");
   property p_retry;
      retry_expired |-> $past(pci_retry);
   endproperty
   a_retry: assert property (p_retry) else $error("retry expiry without retry");
   property p_mask;
      (arb_req_masked & ~$past(arb_req)) == 5'h0;
   endproperty
   a_mask: assert property (p_mask) else $error("masked request without request");
   property p_gate;
      clk_gate |-> $past(pm_state) != bcc_pkg::PM_L0;
   endproperty
   a_gate: assert property (p_gate) else $error("clock gated in L0");
   property p_cfg;
      cfg_stop |=> ##1 !cfg_expired;
   endproperty
   a_cfg: assert property (p_cfg) else $error("retry timer expired after stop");
   property p_cpl;
      cpl_done |=> ##1 !cpl_expired;
   endproperty
   a_cpl: assert property (p_cpl) else $error("completion timer expired after done");
endmodule

bind bcc_regs bcc_regs_chk u_chk (.clk_sys, .rst, .apb_req, .prdata, .credit_freed,
   .fc_update, .pci_retry, .retry_expired, .cfg_stop, .cfg_expired, .cpl_done,
   .cpl_expired, .pm_state, .clk_gate, .arb_req, .arb_req_masked);

// >>> verification/bcc_far_model.sv
// PCI side stand-in: issues a counted burst of retry or freed-credit pulses.
// Pulses come every other cycle, as a master cannot retry back to back.
`timescale 1ns/1ps
module bcc_far_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic go,
   input wire logic kind,
   input wire logic [9:0] cnt,
   output logic pci_retry,
   output logic credit_freed,
   output logic busy
);
   logic [9:0] left_q;
   logic ph_q;
   logic k_q;
   assign busy = left_q != 10'h0;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         left_q <= 10'h0;
         ph_q <= 1'h0;
         k_q <= 1'h0;
         pci_retry <= 1'h0;
         credit_freed <= 1'h0;
      end else begin
         pci_retry <= 1'h0;
         credit_freed <= 1'h0;
         if (go) begin
            left_q <= cnt;
            k_q <= kind;
            ph_q <= 1'h0;
         end else if (busy) begin
            ph_q <= !ph_q;
            if (!ph_q) begin
               left_q <= left_q - 10'h1;
               credit_freed <= k_q;
               pci_retry <= !k_q;
            end
         end
      end
   end
endmodule

// >>> verification/tb.sv
// Self-checking bench for the chip control register block.
// Drives APB, timer and event inputs; the far model supplies retry and credit pulses.
`timescale 1ns/1ps
module tb;
   localparam logic [23:0] CFG3 = 24'h32;
   localparam logic [23:0] CPL0 = 24'h14;
   localparam logic [15:0] DTL = 16'h64;
   localparam logic [15:0] DTM = 16'h50;
   typedef struct packed {
      logic w; logic [7:0] a; logic [31:0] d; logic [31:0] r; logic [3:0] o;
   } bcc_row_t;
   bcc_row_t rows [7] = '{
      '{1'h0, 8'h40, 32'h0, 32'hc920_0000, 4'h0},
      '{1'h0, 8'h48, 32'h0, 32'h1f, 4'h0},
      '{1'h0, 8'h44, 32'h0, 32'h0, 4'h0},
      '{1'h1, 8'h40, 32'hffff_ffff, 32'hfffe_8000, 4'hf},
      '{1'h1, 8'h44, 32'hffff_ffff, 32'h0, 4'hf},
      '{1'h1, 8'h48, 32'hffff_ffff, 32'h1f, 4'hf},
      '{1'h1, 8'h48, 32'h0a, 32'h0a, 4'hf}};
   logic clk_sys = 1'h0;
   logic rst = 1'h1;
   bcc_pkg::bcc_apb_req_t req = '0;
   bcc_pkg::bcc_pm_t pm = bcc_pkg::PM_L0;
   logic [2:0] st = 3'h0;
   logic [2:0] sp = 3'h0;
   logic go = 1'h0;
   logic kind = 1'h0;
   logic [9:0] cnt = 10'h0;
   logic bsel = 1'h0;
   logic [4:0] arq = 5'h1f;
   logic [31:0] prdata, r;
   logic pready, pslverr, irq, fc, rexp, busy, ino, gate, e, cf, pr;
   logic [2:0] tc, ex;
   logic [4:0] am;
   int num_errors = 0, checked = 0, fcn = 0, rxn = 0, n, n0;
   always #4 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (fc) fcn <= fcn + 1;
   always @(posedge clk_sys) if (rexp) rxn <= rxn + 1;
   bcc_regs #(.CFG_CYC3(CFG3), .CPL_CYC0(CPL0), .DT_LONG_CLKS(DTL), .DT_MID_CLKS(DTM))
      dut (.clk_sys(clk_sys), .rst(rst),
      .apb_req(req), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .credit_freed(cf), .fc_update(fc), .pci_retry(pr), .pci_retry_done(1'h0),
      .retry_expired(rexp), .pci_clk_tick(1'h1), .brctl_discard_sel(bsel),
      .dt_start(st[0]), .dt_stop(sp[0]), .dt_expired(ex[0]), .cfg_start(st[1]),
      .cfg_stop(sp[1]), .cfg_expired(ex[1]), .cpl_start(st[2]), .cpl_done(sp[2]),
      .cpl_expired(ex[2]), .dt_in_order(ino), .mem_tc(tc), .pm_state(pm),
      .clk_gate(gate), .arb_req(arq), .arb_req_masked(am));
   bcc_far_model far (.clk_sys(clk_sys), .rst(rst), .go(go), .kind(kind), .cnt(cnt),
      .pci_retry(pr), .credit_freed(cf), .busy(busy));
   task end_sim;
      if (num_errors == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] x);
      checked++;
      if (g !== x) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      req <= '{1'h1, 1'h0, w, a, 4'hf, d};
      @(posedge clk_sys);
      req.penable <= 1'h1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'h1);
      r = prdata;
      e = pslverr;
      req.psel <= 1'h0;
      req.penable <= 1'h0;
      @(posedge clk_sys);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'h0, a, 32'h0);
      chk(r, x);
   endtask
   // Pulses a timer start, optionally stops it, then counts cycles to expiry (200 = none).
   task tm(input int i, input logic stop, output int c);
      st[i] <= 1'h1;
      @(posedge clk_sys);
      st[i] <= 1'h0;
      if (stop) begin
         repeat (5) @(posedge clk_sys);
         sp[i] <= 1'h1;
         @(posedge clk_sys);
         sp[i] <= 1'h0;
      end
      c = 0;
      while (ex[i] !== 1'h1 && c < 200) begin
         @(posedge clk_sys);
         c++;
      end
   endtask
   task send(input logic k, input logic [9:0] c);
      kind <= k;
      cnt <= c;
      go <= 1'h1;
      @(posedge clk_sys);
      go <= 1'h0;
      @(posedge clk_sys);
      for (int i = 0; i < 600 && busy; i++) @(posedge clk_sys);
      repeat (3) @(posedge clk_sys);
   endtask
   task pmchk(input bcc_pkg::bcc_pm_t p, input logic x);
      pm <= p;
      repeat (2) @(posedge clk_sys);
      chk(32'(gate), 32'(x));
   endtask
   initial begin
      #100000;
      num_errors++;
      end_sim();
   end
   initial begin
      repeat (5) @(posedge clk_sys);
      rst <= 1'h0;
      @(posedge clk_sys);
      foreach (rows[i]) begin
         if (rows[i].w) apb(1'h1, rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].r);
         chk(32'({ino, tc}), 32'(rows[i].o));
      end
      chk(32'(am), 32'h0a);
      arq <= 5'h13;
      repeat (2) @(posedge clk_sys);
      chk(32'(am), 32'h02);
      apb(1'h0, 8'h10, 32'h0);
      chk(32'(e), 32'h1);
      pmchk(bcc_pkg::PM_L1, 1'h1);
      pmchk(bcc_pkg::PM_L0S, 1'h1);
      pmchk(bcc_pkg::PM_L0, 1'h0);
      tm(0, 1'h0, n);
      chk(32'(n), 32'hc8);
      tm(2, 1'h0, n);
      chk(32'(n), 32'hc8);
      apb(1'h1, 8'h40, 32'hecf2_0000);
      rd(8'h40, 32'hecf2_0000);
      chk(32'(tc), 32'h5);
      tm(1, 1'h0, n);
      chk(32'(n >= int'(CFG3) && n <= int'(CFG3) + 2), 32'h1);
      tm(2, 1'h0, n);
      chk(32'(n >= int'(CPL0) && n <= int'(CPL0) + 2), 32'h1);
      tm(0, 1'h0, n);
      chk(32'(n >= 64 && n <= 66), 32'h1);
      apb(1'h1, 8'h40, 32'hece2_0000);
      tm(0, 1'h0, n);
      chk(32'(n >= int'(DTL) && n <= int'(DTL) + 2), 32'h1);
      bsel <= 1'h1;
      tm(0, 1'h0, n);
      chk(32'(n >= int'(DTM) && n <= int'(DTM) + 2), 32'h1);
      tm(1, 1'h1, n);
      chk(32'(n), 32'hc8);
      tm(2, 1'h1, n);
      chk(32'(n), 32'hc8);
      n0 = fcn;
      send(1'h1, 10'h4);
      chk(32'(fcn - n0), 32'h2);
      apb(1'h1, 8'h40, 32'hecf2_8000);
      send(1'h1, 10'h3);
      chk(32'(fcn - n0), 32'h5);
      send(1'h0, 10'hff);
      rd(8'h40, 32'hecf2_8000);
      send(1'h0, 10'h1);
      rd(8'h40, 32'hecf3_8000);
      chk(32'(rxn), 32'h1);
      chk(32'(irq), 32'h0);
      apb(1'h1, 8'h88, 32'h1);
      chk(32'(irq), 32'h1);
      apb(1'h1, 8'h40, 32'hecf2_8000);
      rd(8'h40, 32'hecf3_8000);
      apb(1'h1, 8'h84, 32'h1);
      chk(32'(irq), 32'h0);
      apb(1'h1, 8'h40, 32'hecf3_8000);
      rd(8'h40, 32'hecf2_8000);
      apb(1'h1, 8'h40, 32'h6cf2_8000);
      pmchk(bcc_pkg::PM_L0S, 1'h0);
      pmchk(bcc_pkg::PM_L1, 1'h1);
      // A second reset in mid-run must bring back the control and arbiter reset values and clear irq.
      rst <= 1'h1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'h0;
      @(posedge clk_sys);
      rd(8'h40, 32'hc920_0000);
      rd(8'h48, 32'h1f);
      chk(32'(irq), 32'h0);
      end_sim();
   end
endmodule
